// ### include/fnd_pkg.sv
// constants shared by the fractional-n divider chain
package fnd_pkg;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_REF  = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;
  // --------------------------------------------------------------
  // field widths and reset values
  // --------------------------------------------------------------
  localparam int unsigned MAIN_W = 15;
  localparam int unsigned REF_W  = 9;
  localparam int unsigned N_W    = 13;
  localparam int unsigned K_W    = 2;
  localparam int unsigned CTRL_W = 4;
  localparam logic [14:0] MAIN_RST = 15'h0000;
  localparam logic [8:0]  REF_RST  = 9'h000;
  localparam logic [8:0]  REF_MIN  = 9'h002;
  localparam logic [3:0]  CTRL_RST = 4'h0;
  // control bits
  localparam int unsigned CTRL_TEST = 0;
  localparam int unsigned CTRL_TRI  = 1;
  localparam int unsigned CTRL_SW_A = 2;
  localparam int unsigned CTRL_SW_C = 3;
  // status bits
  localparam int unsigned STAT_LOADED = 0;
  localparam int unsigned STAT_PEND   = 1;
  localparam int unsigned STAT_LOCK   = 2;
  // --------------------------------------------------------------
  // lock detector timing, counted on the link clock
  // --------------------------------------------------------------
  localparam int unsigned LOCK_WIN_NS    = 250;
  localparam int unsigned LINK_PERIOD_NS = 160;
  localparam int unsigned LOCK_CYC_RAW   = LOCK_WIN_NS / LINK_PERIOD_NS;
  localparam logic [3:0]  LOCK_CYC = (LOCK_CYC_RAW < 1) ? 4'h1 : 4'(LOCK_CYC_RAW);
  localparam logic [2:0]  LOCK_RUN = 3'h7;
endpackage

// ### rtl/fnd_divider_chain.sv
// fractional-n divider chain with avalon-mm register slave
// Summary of operation
// - 9-bit programmable reference divider, clamped at a minimum, divides reference clock.
// - comparison rate is four times raster; effective reference factor is the programmed (clamped) value.
// - test select routes reference divider output onto switch output a.
// - 13-bit main divider ratio n, each cycle uses n or n+1 by fraction unit.
// - averaged main factor equals n plus k quarters, k from 0 to 3.
// - main factor is 15-bit binary; software programs only 2048 to 32767.
// - test select routes main divider output onto switch output c.
// - both dividers held in reset until a complete main factor is written.
// - new settings apply only after the bus write has completed.
// - settings apply only while the charge pump neither sources nor sinks.
// - phase detector drives source or sink from reference versus main phase.
// - lock indicated after seven successive comparisons within about 250 ns.
// - charge pump tristate bit disables lock detection and pump outputs.
`timescale 1ns/1ps
module fnd_divider_chain (
  // system clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // avalon-mm slave
  input  wire logic [3:0]  avm_address_in,
  input  wire logic        avm_read_in,
  input  wire logic        avm_write_in,
  input  wire logic [31:0] avm_writedata_in,
  input  wire logic [3:0]  avm_byteenable_in,
  output logic [31:0]      avm_readdata_out,
  output logic             avm_waitrequest_out,
  // link side: reference oscillator clock and divided vco pin
  input  wire logic        ref_clk_in,
  input  wire logic        vco_div_in,
  // pump, lock and switching outputs (ref_clk_in domain)
  output logic             pump_src_out,
  output logic             pump_snk_out,
  output logic             lock_indicator_out,
  output logic             switch_out_a,
  output logic             switch_out_c
);
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // byte-lane merge of a write into a 32-bit image
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // --------------------------------------------------------------
  // bus slave (clk_in domain)
  // --------------------------------------------------------------
  logic [14:0] main_q;
  logic [8:0]  ref_q;
  logic [3:0]  ctrl_q;
  logic        loaded_q;
  logic        dirty_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        req_q;
  logic [14:0] x_main_q;
  logic [8:0]  x_ref_q;
  logic [3:0]  x_ctrl_q;
  logic [1:0]  ack_s_q;
  logic [1:0]  lock_s_q;
  logic        ack_q;
  logic        lock_q;
  logic        acc_wr;
  logic        pend;
  logic        launch;
  logic [31:0] stat_v;

  assign acc_wr = avm_write_in && !wait_q;
  assign pend   = req_q != ack_s_q[1];
  assign launch = dirty_q && !pend;
  assign stat_v = {29'h0, lock_s_q[1], pend | dirty_q, loaded_q};

  // one wait cycle per access, then waitrequest low for one edge
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
    end else if (wait_q) begin
      wait_q <= !(avm_read_in || avm_write_in);
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read data captured while waitrequest drops
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (wait_q && avm_read_in) begin
      unique case (avm_address_in)
        fnd_pkg::ADDR_MAIN: rdata_q <= {17'h0, main_q};
        fnd_pkg::ADDR_REF:  rdata_q <= {23'h0, ref_q};
        fnd_pkg::ADDR_CTRL: rdata_q <= {28'h0, ctrl_q};
        fnd_pkg::ADDR_STAT: rdata_q <= stat_v;
        default:            rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // shadow registers, written at the completing edge
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      main_q <= fnd_pkg::MAIN_RST;
      ref_q  <= fnd_pkg::REF_RST;
      ctrl_q <= fnd_pkg::CTRL_RST;
    end else if (acc_wr) begin
      unique case (avm_address_in)
        fnd_pkg::ADDR_MAIN:
          main_q <= 15'(be_merge({17'h0, main_q}, avm_writedata_in, avm_byteenable_in));
        fnd_pkg::ADDR_REF:
          ref_q <= 9'(be_merge({23'h0, ref_q}, avm_writedata_in, avm_byteenable_in));
        fnd_pkg::ADDR_CTRL:
          ctrl_q <= 4'(be_merge({28'h0, ctrl_q}, avm_writedata_in, avm_byteenable_in));
        default: ;
      endcase
    end
  end

  // dirty flag: a new write wins over the clear at launch
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dirty_q  <= 1'b0;
      loaded_q <= 1'b0;
    end else begin
      if (acc_wr && avm_address_in != fnd_pkg::ADDR_STAT &&
          avm_address_in inside {fnd_pkg::ADDR_MAIN, fnd_pkg::ADDR_REF,
                                 fnd_pkg::ADDR_CTRL}) begin
        dirty_q <= 1'b1;
      end else if (launch) begin
        dirty_q <= 1'b0;
      end
      if (acc_wr && avm_address_in == fnd_pkg::ADDR_MAIN &&
          avm_byteenable_in[1:0] == 2'b11) begin
        loaded_q <= 1'b1;
      end
    end
  end

  // snapshot held stable while the link side picks it up
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_q    <= 1'b0;
      x_main_q <= fnd_pkg::MAIN_RST;
      x_ref_q  <= fnd_pkg::REF_RST;
      x_ctrl_q <= fnd_pkg::CTRL_RST;
    end else if (launch) begin
      req_q    <= !req_q;
      x_main_q <= main_q;
      x_ref_q  <= ref_q;
      x_ctrl_q <= ctrl_q;
    end
  end

  // acknowledge and lock brought back from the link domain
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_s_q  <= 2'b00;
      lock_s_q <= 2'b00;
    end else begin
      ack_s_q  <= {ack_s_q[0], ack_q};
      lock_s_q <= {lock_s_q[0], lock_q};
    end
  end

  assign avm_waitrequest_out = wait_q;
  assign avm_readdata_out    = rdata_q;

  // --------------------------------------------------------------
  // link side (ref_clk_in domain)
  // --------------------------------------------------------------
  logic [2:0]  req_s_q;
  logic [2:0]  vco_s_q;
  logic        pend_l_q;
  logic        run_q;
  logic        l_load_q;
  logic [14:0] a_main_q;
  logic [8:0]  a_ref_q;
  logic [3:0]  a_ctrl_q;
  logic [8:0]  rcnt_q;
  logic [13:0] mcnt_q;
  logic [1:0]  acc_q;
  logic        plus1_q;
  logic        up_q;
  logic        dn_q;
  logic        rtest_q;
  logic        mtest_q;
  logic [3:0]  wid_q;
  logic [2:0]  good_q;
  logic        src_q;
  logic        snk_q;
  logic        sw_a_q;
  logic        sw_c_q;
  logic [8:0]  ref_eff;
  logic [13:0] ratio;
  logic [2:0]  acc_sum;
  logic        ref_tick;
  logic        main_tick;
  logic        vco_rise;
  logic        both;
  logic        apply;

  // clamp reference factor at its minimum
  assign ref_eff  = (a_ref_q < fnd_pkg::REF_MIN) ? fnd_pkg::REF_MIN : a_ref_q;
  // n from upper bits, plus one when the fraction carries
  assign ratio    = {1'b0, a_main_q[14:2]} + {13'h0, plus1_q};
  assign acc_sum  = {1'b0, acc_q} + {1'b0, a_main_q[1:0]};
  assign vco_rise = vco_s_q[1] && !vco_s_q[2];
  assign ref_tick  = run_q && rcnt_q == ref_eff - 9'h001;
  assign main_tick = run_q && vco_rise && mcnt_q == ratio - 14'h0001;
  assign both  = (up_q || ref_tick) && (dn_q || main_tick);
  assign apply = pend_l_q && !up_q && !dn_q;

  // synchronisers: request toggle and vco pin
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_s_q <= 3'b000;
      vco_s_q <= 3'b000;
    end else begin
      req_s_q <= {req_s_q[1:0], req_q};
      vco_s_q <= {vco_s_q[1:0], vco_div_in};
    end
  end

  // settings wait for an idle pump, then apply
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_l_q <= 1'b0;
      ack_q    <= 1'b0;
      a_main_q <= fnd_pkg::MAIN_RST;
      a_ref_q  <= fnd_pkg::REF_RST;
      a_ctrl_q <= fnd_pkg::CTRL_RST;
      l_load_q <= 1'b0;
    end else begin
      if (req_s_q[2] != req_s_q[1]) begin
        pend_l_q <= 1'b1;
      end else if (apply) begin
        pend_l_q <= 1'b0;
      end
      if (apply) begin
        ack_q    <= !ack_q;
        a_main_q <= x_main_q;
        a_ref_q  <= x_ref_q;
        a_ctrl_q <= x_ctrl_q;
        l_load_q <= loaded_q;
      end
    end
  end

  // dividers held in reset until a full main factor is in
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= l_load_q;
    end
  end

  // reference divider
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rcnt_q  <= 9'h000;
      rtest_q <= 1'b0;
    end else if (!run_q) begin
      rcnt_q  <= 9'h000;
      rtest_q <= 1'b0;
    end else if (ref_tick) begin
      rcnt_q  <= 9'h000;
      rtest_q <= !rtest_q;
    end else begin
      rcnt_q <= rcnt_q + 9'h001;
    end
  end

  // main divider with fraction accumulator
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mcnt_q  <= 14'h0000;
      acc_q   <= 2'b00;
      plus1_q <= 1'b0;
      mtest_q <= 1'b0;
    end else if (!run_q) begin
      mcnt_q  <= 14'h0000;
      acc_q   <= 2'b00;
      plus1_q <= 1'b0;
      mtest_q <= 1'b0;
    end else if (main_tick) begin
      mcnt_q  <= 14'h0000;
      acc_q   <= acc_sum[1:0];
      plus1_q <= acc_sum[2];
      mtest_q <= !mtest_q;
    end else if (vco_rise) begin
      mcnt_q <= mcnt_q + 14'h0001;
    end
  end

  // tristate phase detector
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else if (both || !run_q) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= up_q || ref_tick;
      dn_q <= dn_q || main_tick;
    end
  end

  // lock detector: width of each phase error pulse
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wid_q  <= 4'h0;
      good_q <= 3'h0;
      lock_q <= 1'b0;
    end else if (a_ctrl_q[fnd_pkg::CTRL_TRI] || !run_q) begin
      wid_q  <= 4'h0;
      good_q <= 3'h0;
      lock_q <= 1'b0;
    end else if (both) begin
      wid_q <= 4'h0;
      if (wid_q <= fnd_pkg::LOCK_CYC) begin
        good_q <= (good_q == fnd_pkg::LOCK_RUN) ? good_q : good_q + 3'h1;
        lock_q <= good_q >= fnd_pkg::LOCK_RUN - 3'h1;
      end else begin
        good_q <= 3'h0;
        lock_q <= 1'b0;
      end
    end else if (up_q || dn_q) begin
      wid_q <= (wid_q == 4'hf) ? wid_q : wid_q + 4'h1;
    end
  end

  // registered pump and switching outputs
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      src_q <= 1'b0;
      snk_q  <= 1'b0;
      sw_a_q <= 1'b0;
      sw_c_q <= 1'b0;
    end else begin
      src_q <= up_q && !dn_q && !a_ctrl_q[fnd_pkg::CTRL_TRI];
      snk_q <= dn_q && !up_q && !a_ctrl_q[fnd_pkg::CTRL_TRI];
      sw_a_q <= a_ctrl_q[fnd_pkg::CTRL_TEST] ? rtest_q : a_ctrl_q[fnd_pkg::CTRL_SW_A];
      sw_c_q <= a_ctrl_q[fnd_pkg::CTRL_TEST] ? mtest_q : a_ctrl_q[fnd_pkg::CTRL_SW_C];
    end
  end

  assign pump_src_out       = src_q;
  assign pump_snk_out       = snk_q;
  assign lock_indicator_out = lock_q;
  assign switch_out_a       = sw_a_q;
  assign switch_out_c       = sw_c_q;
endmodule

// ### testbench/fnd_divider_chain_asserts.sv
// port-level assertions for the divider chain
`timescale 1ns/1ps
module fnd_chain_chk (
  // clocks and reset
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        ref_clk_in,
  // register bus
  input wire logic [3:0]  avm_address_in,
  input wire logic        avm_read_in,
  input wire logic        avm_write_in,
  input wire logic [3:0]  avm_byteenable_in,
  input wire logic [31:0] avm_readdata_out,
  input wire logic        avm_waitrequest_out,
  // link outputs
  input wire logic        pump_src_out,
  input wire logic        pump_snk_out,
  input wire logic        lock_indicator_out
);
  logic loaded_q;
  // main factor seen written in full on the bus
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      loaded_q <= 1'b0;
    end else if (avm_write_in && !avm_waitrequest_out && &avm_byteenable_in[1:0]
                 && avm_address_in == fnd_pkg::ADDR_MAIN) begin
      loaded_q <= 1'b1;
    end
  end
  // bus handshake: one wait cycle, one-cycle answer
  AST_ACCEPT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (avm_read_in || avm_write_in) && avm_waitrequest_out |=> !avm_waitrequest_out)
    else $error("request not answered next cycle");
  AST_PULSE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !avm_waitrequest_out |=> avm_waitrequest_out)
    else $error("waitrequest low too long");
  AST_IDLE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(avm_read_in || avm_write_in) |=> avm_waitrequest_out)
    else $error("answer without request");
  AST_RD_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !avm_read_in |=> $stable(avm_readdata_out))
    else $error("read data moved without read");
  AST_UNMAPPED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    avm_read_in && !avm_waitrequest_out && avm_address_in[1:0] != 2'h0
    |-> avm_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_REF_UPPER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    avm_read_in && !avm_waitrequest_out && avm_address_in == fnd_pkg::ADDR_REF
    |-> avm_readdata_out[31:9] == 23'h0)
    else $error("reference factor wider than nine bits");
  AST_MAIN_UPPER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    avm_read_in && !avm_waitrequest_out && avm_address_in == fnd_pkg::ADDR_MAIN
    |-> avm_readdata_out[31:15] == 17'h0)
    else $error("main factor wider than fifteen bits");
  // link side
  AST_PUMP_EXCL: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !(pump_src_out && pump_snk_out))
    else $error("pump sources and sinks at once");
  AST_HELD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !loaded_q |-> !pump_src_out && !pump_snk_out && !lock_indicator_out)
    else $error("dividers active before main factor written");
endmodule

bind fnd_divider_chain fnd_chain_chk fnd_chain_chk_inst (
  .clk_in, .sys_rst_in, .ref_clk_in, .avm_address_in, .avm_read_in,
  .avm_write_in, .avm_byteenable_in, .avm_readdata_out, .avm_waitrequest_out,
  .pump_src_out, .pump_snk_out, .lock_indicator_out);

// ### testbench/fnd_vco_model.sv
// divided vco source feeding the main divider pin
`timescale 1ns/1ps
module fnd_vco_model #(
  parameter int HALF = 2
) (
  // link clock and reset
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  // divided vco level
  output logic      vco_div_out
);
  int cnt_q;
  // toggle every HALF link cycles, never under two periods
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q       <= 0;
      vco_div_out <= 1'b0;
    end else if (cnt_q == HALF - 1) begin
      cnt_q       <= 0;
      vco_div_out <= ~vco_div_out;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// ### testbench/fnd_divider_chain_bench.sv
// self-checking bench for the divider chain
`timescale 1ns/1ps
module fnd_divider_chain_bench;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, ref_clk_in = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0, wr = 1'b0, waitrq, vco, src, snk, lock, sw_a, sw_c;
  logic [31:0] wdata = 32'h0, rdata, tmp;
  logic [31:0] exp_q[$], msk_q[$];
  logic [14:0] main_v;
  logic [8:0]  ref_v;
  int          failures = 0, samples_checked = 0, cycles = 0, seed = 45268;
  int          ta, tc, ts, tk;
  // clocks: system 20 ns, link 160 ns with unrelated phase
  always #10 clk_in = ~clk_in;
  initial begin
    #7;
    forever #80 ref_clk_in = ~ref_clk_in;
  end
  fnd_divider_chain fnd_divider_chain_inst (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avm_address_in(addr),
    .avm_read_in(rd), .avm_write_in(wr), .avm_writedata_in(wdata),
    .avm_byteenable_in(4'hf), .avm_readdata_out(rdata), .avm_waitrequest_out(waitrq),
    .ref_clk_in(ref_clk_in), .vco_div_in(vco), .pump_src_out(src),
    .pump_snk_out(snk), .lock_indicator_out(lock), .switch_out_a(sw_a),
    .switch_out_c(sw_c));
  fnd_vco_model fnd_vco_model_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .vco_div_out(vco));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= d;
    @(posedge clk_in);
    while (waitrq !== 1'b0) @(posedge clk_in);
    tmp = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(a, 1'b0, 32'h0);
  endtask
  // poll until the snapshot has reached the link side
  // apply may wait a whole main division cycle; only the hang guard ends it
  task automatic settle;
    tmp[fnd_pkg::STAT_PEND] = 1'b1;
    while (tmp[fnd_pkg::STAT_PEND] !== 1'b0) begin
      rd_chk(fnd_pkg::ADDR_STAT, 32'h0, 32'h0);
    end
    repeat (4) @(posedge ref_clk_in);
  endtask
  task automatic watch(input int n);
    logic pa, pc;
    ta = 0;
    tc = 0;
    ts = 0;
    tk = 0;
    pa = sw_a;
    pc = sw_c;
    repeat (n) begin
      @(negedge ref_clk_in);
      ta += int'(sw_a !== pa);
      tc += int'(sw_c !== pc);
      ts += int'(src === 1'b1);
      tk += int'(snk === 1'b1);
      pa = sw_a;
      pc = sw_c;
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // result monitor: oldest note against each read answer
  always @(posedge clk_in) begin
    if (rd && !waitrq && exp_q.size() > 0) begin
      check(rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      report_and_stop();
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd_chk(fnd_pkg::ADDR_MAIN, 32'(fnd_pkg::MAIN_RST), 32'hffffffff);
    rd_chk(fnd_pkg::ADDR_REF, 32'(fnd_pkg::REF_RST), 32'hffffffff);
    rd_chk(fnd_pkg::ADDR_CTRL, 32'(fnd_pkg::CTRL_RST), 32'hffffffff);
    rd_chk(fnd_pkg::ADDR_STAT, 32'h0, 32'hffffffff);
    rd_chk(4'h6, 32'h0, 32'hffffffff);
    // reference factor with junk above nine bits, test select still off
    ref_v = 9'(($random(seed) & 3) + 3);
    bus(fnd_pkg::ADDR_REF, 1'b1, {23'($random(seed)), ref_v});
    rd_chk(fnd_pkg::ADDR_REF, 32'(ref_v), 32'hffffffff);
    // plain switching function with test select off, dividers still held
    for (int i = 0; i < 4; i++) begin
      bus(fnd_pkg::ADDR_CTRL, 1'b1, 32'(i << fnd_pkg::CTRL_SW_A));
      rd_chk(fnd_pkg::ADDR_CTRL, 32'(i << fnd_pkg::CTRL_SW_A), 32'hffffffff);
      settle();
      check(32'({sw_c, sw_a}), 32'(i));
    end
    bus(fnd_pkg::ADDR_CTRL, 1'b1, 32'h1);
    settle();
    watch(60);
    check(32'(ta + tc + ts + tk), 32'h0);
    // lowest main factor with random fraction
    main_v = 15'h0800 + 15'($random(seed) & 3);
    bus(fnd_pkg::ADDR_MAIN, 1'b1, {17'($random(seed)), main_v});
    rd_chk(fnd_pkg::ADDR_MAIN, 32'(main_v), 32'hffffffff);
    settle();
    rd_chk(fnd_pkg::ADDR_STAT, 32'h1, 32'h1);
    watch(6200);
    check(32'(ta >= 6200 / ref_v - 1 && ta <= 6200 / ref_v + 1), 32'h1);
    check(32'(tc >= 6200 / main_v - 1 && tc <= 6200 / main_v + 1), 32'h1);
    // reference far faster than main: pump sources, never sinks, no lock
    check(32'(tk), 32'h0);
    check(32'(ts > 3100), 32'h1);
    check(32'(lock), 32'h0);
    // read-only status and unmapped writes leave state alone
    bus(fnd_pkg::ADDR_STAT, 1'b1, 32'h0);
    bus(4'h5, 1'b1, 32'hffffffff);
    rd_chk(fnd_pkg::ADDR_STAT, 32'h1, 32'h1);
    rd_chk(fnd_pkg::ADDR_MAIN, 32'(main_v), 32'hffffffff);
    report_and_stop();
  end
endmodule
